// ---- verilog/amc_config_header.sv ----
// configuration header and range register bank, address-map function
// assumes a configuration port presenting one-cycle read/write requests
// range words keep reserved bits as written; software masks them
//
// Behaviour
// R1 - Unimplemented standard header offsets read as zero and ignore writes.
// R2 - Software keeps away from unimplemented extended offsets.
// R3 - Offset zero low half returns a fixed maker identification code.
// R4 - Offset zero high half returns a fixed function identification code.
// R5 - Class word top byte reads the host bridge base class and is fixed.
// R6 - Subclass byte reads zero and cannot be written.
// R7 - Programming interface byte reads zero and cannot be written.
// R8 - Class word low byte holds a fixed silicon revision code.
// R9 - Header type byte reads the multi-function ordinary header code.
// R10 - Cache line size byte reads zero and cannot be written.
// R11 - Latency timer byte reads zero and cannot be written.
// R12 - Self-test byte reads zero and cannot be written.
// R13 - Eight memory-mapped range base/limit pairs are read/write words.
// R14 - Four configuration range words are read/write at consecutive offsets.
// R15 - Writes to read-only header fields complete quietly with no effect.
// R16 - Range registers return the last written bits, updated on the write.
`timescale 1ns/1ns
`include "amc_defs.svh"

module amc_config_header #(
   // arbitrary neutral identification values
   parameter logic [15:0] MAKER_IDENT    = 16'h5a5a,
   parameter logic [15:0] FUNCTION_IDENT = 16'h0001,
   parameter logic [7:0]  REVISION       = 8'h01
) (
   // clock and reset
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   // configuration port
   input  wire amc_pkg::amc_req_t req_in,
   output      amc_pkg::amc_rsp_t rsp_out,
   output      logic              wr_done_out
);
   import amc_pkg::*;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // cleared at reset so a read is never unknown
   logic [31:0] range_q [`AMC_RANGE_WORDS];
   amc_rsp_t    rsp_q;
   logic        wr_done_q;

   // explicit table: any hole in the span stays unmapped
   function automatic logic [5:0] slot_of(input logic [7:0] ofs);
      logic [5:0] s;
      case (ofs)
         // dram regions 4 to 7
         `AMC_OFS_DRAM4_BASE:  s = 6'h00;
         `AMC_OFS_DRAM4_LIMIT: s = 6'h01;
         `AMC_OFS_DRAM5_BASE:  s = 6'h02;
         `AMC_OFS_DRAM5_LIMIT: s = 6'h03;
         `AMC_OFS_DRAM6_BASE:  s = 6'h04;
         `AMC_OFS_DRAM6_LIMIT: s = 6'h05;
         `AMC_OFS_DRAM7_BASE:  s = 6'h06;
         `AMC_OFS_DRAM7_LIMIT: s = 6'h07;
         // mmio regions 0 to 7
         `AMC_OFS_MMIO0_BASE:  s = 6'h08;
         `AMC_OFS_MMIO0_LIMIT: s = 6'h09;
         `AMC_OFS_MMIO1_BASE:  s = 6'h0a;
         `AMC_OFS_MMIO1_LIMIT: s = 6'h0b;
         `AMC_OFS_MMIO2_BASE:  s = 6'h0c;
         `AMC_OFS_MMIO2_LIMIT: s = 6'h0d;
         `AMC_OFS_MMIO3_BASE:  s = 6'h0e;
         `AMC_OFS_MMIO3_LIMIT: s = 6'h0f;
         `AMC_OFS_MMIO4_BASE:  s = 6'h10;
         `AMC_OFS_MMIO4_LIMIT: s = 6'h11;
         `AMC_OFS_MMIO5_BASE:  s = 6'h12;
         `AMC_OFS_MMIO5_LIMIT: s = 6'h13;
         `AMC_OFS_MMIO6_BASE:  s = 6'h14;
         `AMC_OFS_MMIO6_LIMIT: s = 6'h15;
         `AMC_OFS_MMIO7_BASE:  s = 6'h16;
         `AMC_OFS_MMIO7_LIMIT: s = 6'h17;
         // io port regions 0 to 3
         `AMC_OFS_IOP0_BASE:   s = 6'h18;
         `AMC_OFS_IOP0_LIMIT:  s = 6'h19;
         `AMC_OFS_IOP1_BASE:   s = 6'h1a;
         `AMC_OFS_IOP1_LIMIT:  s = 6'h1b;
         `AMC_OFS_IOP2_BASE:   s = 6'h1c;
         `AMC_OFS_IOP2_LIMIT:  s = 6'h1d;
         `AMC_OFS_IOP3_BASE:   s = 6'h1e;
         `AMC_OFS_IOP3_LIMIT:  s = 6'h1f;
         // config ranges and memory gap
         `AMC_OFS_CFG_RANGE0:  s = 6'h20;
         `AMC_OFS_CFG_RANGE1:  s = 6'h21;
         `AMC_OFS_CFG_RANGE2:  s = 6'h22;
         `AMC_OFS_CFG_RANGE3:  s = 6'h23;
         `AMC_OFS_GAP_WINDOW:  s = 6'h24;
         default:              s = `AMC_NO_SLOT;
      endcase
      return s;
   endfunction : slot_of

   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   // offset bits 1:0 dropped: word access only
   // a write wins over a read in the same cycle; no answer then
   // slot_hit also keeps the no-slot code off the array index
   logic [7:0] word_ofs;
   logic [5:0] wr_slot;
   logic       slot_hit;
   logic       rd_take;
   logic       wr_take;

   assign word_ofs = {req_in.offset[7:2], 2'b00};
   assign wr_slot  = slot_of(word_ofs);
   assign slot_hit = (wr_slot != `AMC_NO_SLOT);
   assign rd_take  = req_in.rd && !req_in.wr;
   assign wr_take  = req_in.wr;

   // ------------------------------------------------------------
   // range register writes
   // ------------------------------------------------------------
   // word aligned offsets only; low two bits are ignored
   // R13 base/limit pairs
   // R14 config range words
   // R16 update on write
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         for (int i = 0; i < `AMC_RANGE_WORDS; i++) begin
            range_q[i] <= `AMC_RANGE_RESET;
         end
      end else if (wr_take && slot_hit) begin
         range_q[wr_slot] <= lane_merge(range_q[wr_slot],
                                        req_in.wdata,
                                        req_in.byte_en);
      end
   end

   // ------------------------------------------------------------
   // write completion
   // ------------------------------------------------------------
   // R15 accept read-only writes
   // pulses for every write, mapped or not
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         wr_done_q <= 1'b0;
      end else begin
         wr_done_q <= req_in.wr;
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   // a read in the same cycle as a write is dropped and gets no answer
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= rd_take;
         if (rd_take) begin
            case (word_ofs)
               // R3 maker code
               // R4 function code
               `AMC_OFS_IDENT: begin
                  rsp_q.rdata <= {FUNCTION_IDENT, MAKER_IDENT};
               end
               // R5 base class
               // R6 subclass zero
               // R7 interface zero
               // R8 revision code
               `AMC_OFS_CLASS: begin
                  rsp_q.rdata <= {`AMC_BASE_CLASS, `AMC_SUBCLASS,
                                  `AMC_CLASS_IF, REVISION};
               end
               // R9 header code
               // R10 line size zero
               // R11 latency zero
               // R12 self test zero
               `AMC_OFS_HEADER: begin
                  rsp_q.rdata <= {`AMC_SELF_TEST, `AMC_HEADER_CODE,
                                  `AMC_LATENCY, `AMC_LINE_SIZE};
               end

               // R16 dram region readback
               // base word first, limit word next
               // dram region 4 base
               `AMC_OFS_DRAM4_BASE: begin
                  rsp_q.rdata <= range_q[6'h00];
               end
               // dram region 4 limit
               `AMC_OFS_DRAM4_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h01];
               end
               // dram region 5 base
               `AMC_OFS_DRAM5_BASE: begin
                  rsp_q.rdata <= range_q[6'h02];
               end
               // dram region 5 limit
               `AMC_OFS_DRAM5_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h03];
               end
               // dram region 6 base
               `AMC_OFS_DRAM6_BASE: begin
                  rsp_q.rdata <= range_q[6'h04];
               end
               // dram region 6 limit
               `AMC_OFS_DRAM6_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h05];
               end
               // dram region 7 base
               `AMC_OFS_DRAM7_BASE: begin
                  rsp_q.rdata <= range_q[6'h06];
               end
               // dram region 7 limit
               `AMC_OFS_DRAM7_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h07];
               end

               // R13 mmio base/limit pairs
               // eight pairs, base word first
               // mmio region 0 base
               `AMC_OFS_MMIO0_BASE: begin
                  rsp_q.rdata <= range_q[6'h08];
               end
               // mmio region 0 limit
               `AMC_OFS_MMIO0_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h09];
               end
               // mmio region 1 base
               `AMC_OFS_MMIO1_BASE: begin
                  rsp_q.rdata <= range_q[6'h0a];
               end
               // mmio region 1 limit
               `AMC_OFS_MMIO1_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h0b];
               end
               // mmio region 2 base
               `AMC_OFS_MMIO2_BASE: begin
                  rsp_q.rdata <= range_q[6'h0c];
               end
               // mmio region 2 limit
               `AMC_OFS_MMIO2_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h0d];
               end
               // mmio region 3 base
               `AMC_OFS_MMIO3_BASE: begin
                  rsp_q.rdata <= range_q[6'h0e];
               end
               // mmio region 3 limit
               `AMC_OFS_MMIO3_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h0f];
               end
               // mmio region 4 base
               `AMC_OFS_MMIO4_BASE: begin
                  rsp_q.rdata <= range_q[6'h10];
               end
               // mmio region 4 limit
               `AMC_OFS_MMIO4_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h11];
               end
               // mmio region 5 base
               `AMC_OFS_MMIO5_BASE: begin
                  rsp_q.rdata <= range_q[6'h12];
               end
               // mmio region 5 limit
               `AMC_OFS_MMIO5_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h13];
               end
               // mmio region 6 base
               `AMC_OFS_MMIO6_BASE: begin
                  rsp_q.rdata <= range_q[6'h14];
               end
               // mmio region 6 limit
               `AMC_OFS_MMIO6_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h15];
               end
               // mmio region 7 base
               `AMC_OFS_MMIO7_BASE: begin
                  rsp_q.rdata <= range_q[6'h16];
               end
               // mmio region 7 limit
               `AMC_OFS_MMIO7_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h17];
               end

               // R16 io port region readback
               // four pairs, base word first
               // io port region 0 base
               `AMC_OFS_IOP0_BASE: begin
                  rsp_q.rdata <= range_q[6'h18];
               end
               // io port region 0 limit
               `AMC_OFS_IOP0_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h19];
               end
               // io port region 1 base
               `AMC_OFS_IOP1_BASE: begin
                  rsp_q.rdata <= range_q[6'h1a];
               end
               // io port region 1 limit
               `AMC_OFS_IOP1_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h1b];
               end
               // io port region 2 base
               `AMC_OFS_IOP2_BASE: begin
                  rsp_q.rdata <= range_q[6'h1c];
               end
               // io port region 2 limit
               `AMC_OFS_IOP2_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h1d];
               end
               // io port region 3 base
               `AMC_OFS_IOP3_BASE: begin
                  rsp_q.rdata <= range_q[6'h1e];
               end
               // io port region 3 limit
               `AMC_OFS_IOP3_LIMIT: begin
                  rsp_q.rdata <= range_q[6'h1f];
               end

               // R14 config range words
               // base and limit share one word
               // config range 0
               `AMC_OFS_CFG_RANGE0: begin
                  rsp_q.rdata <= range_q[6'h20];
               end
               // config range 1
               `AMC_OFS_CFG_RANGE1: begin
                  rsp_q.rdata <= range_q[6'h21];
               end
               // config range 2
               `AMC_OFS_CFG_RANGE2: begin
                  rsp_q.rdata <= range_q[6'h22];
               end
               // config range 3
               `AMC_OFS_CFG_RANGE3: begin
                  rsp_q.rdata <= range_q[6'h23];
               end

               // R16 memory gap readback
               // single word, zero after reset
               // memory gap window
               `AMC_OFS_GAP_WINDOW: begin
                  rsp_q.rdata <= range_q[6'h24];
               end

               default: begin
                  // R1 unimplemented zero
                  // R2 extended holes also answer zero here
                  // zero rather than the last word seen
                  rsp_q.rdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   assign rsp_out     = rsp_q;
   assign wr_done_out = wr_done_q;

endmodule : amc_config_header

// ---- verilog/amc_defs.svh ----
// constants for the address-map configuration header block
// assumes inclusion by bare name from the package and the top module
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH

// ------------------------------------------------------------
// header offsets
// ------------------------------------------------------------
`define AMC_OFS_IDENT        8'h00
`define AMC_OFS_CLASS        8'h08
`define AMC_OFS_HEADER       8'h0c
`define AMC_STD_LIMIT        8'h40

// ------------------------------------------------------------
// range register span
// ------------------------------------------------------------
`define AMC_OFS_RANGE_FIRST  8'h60
`define AMC_OFS_RANGE_LAST   8'hf0
`define AMC_RANGE_WORDS      37
`define AMC_NO_SLOT          6'h3f

// ------------------------------------------------------------
// range register offsets, one per word
// ------------------------------------------------------------
`define AMC_OFS_DRAM4_BASE   8'h60
`define AMC_OFS_DRAM4_LIMIT  8'h64
`define AMC_OFS_DRAM5_BASE   8'h68
`define AMC_OFS_DRAM5_LIMIT  8'h6c
`define AMC_OFS_DRAM6_BASE   8'h70
`define AMC_OFS_DRAM6_LIMIT  8'h74
`define AMC_OFS_DRAM7_BASE   8'h78
`define AMC_OFS_DRAM7_LIMIT  8'h7c
`define AMC_OFS_MMIO0_BASE   8'h80
`define AMC_OFS_MMIO0_LIMIT  8'h84
`define AMC_OFS_MMIO1_BASE   8'h88
`define AMC_OFS_MMIO1_LIMIT  8'h8c
`define AMC_OFS_MMIO2_BASE   8'h90
`define AMC_OFS_MMIO2_LIMIT  8'h94
`define AMC_OFS_MMIO3_BASE   8'h98
`define AMC_OFS_MMIO3_LIMIT  8'h9c
`define AMC_OFS_MMIO4_BASE   8'ha0
`define AMC_OFS_MMIO4_LIMIT  8'ha4
`define AMC_OFS_MMIO5_BASE   8'ha8
`define AMC_OFS_MMIO5_LIMIT  8'hac
`define AMC_OFS_MMIO6_BASE   8'hb0
`define AMC_OFS_MMIO6_LIMIT  8'hb4
`define AMC_OFS_MMIO7_BASE   8'hb8
`define AMC_OFS_MMIO7_LIMIT  8'hbc
`define AMC_OFS_IOP0_BASE    8'hc0
`define AMC_OFS_IOP0_LIMIT   8'hc4
`define AMC_OFS_IOP1_BASE    8'hc8
`define AMC_OFS_IOP1_LIMIT   8'hcc
`define AMC_OFS_IOP2_BASE    8'hd0
`define AMC_OFS_IOP2_LIMIT   8'hd4
`define AMC_OFS_IOP3_BASE    8'hd8
`define AMC_OFS_IOP3_LIMIT   8'hdc
`define AMC_OFS_CFG_RANGE0   8'he0
`define AMC_OFS_CFG_RANGE1   8'he4
`define AMC_OFS_CFG_RANGE2   8'he8
`define AMC_OFS_CFG_RANGE3   8'hec
`define AMC_OFS_GAP_WINDOW   8'hf0

// ------------------------------------------------------------
// fixed field values
// ------------------------------------------------------------
`define AMC_BASE_CLASS       8'h06
`define AMC_SUBCLASS         8'h00
`define AMC_CLASS_IF         8'h00
`define AMC_HEADER_CODE      8'h80
`define AMC_LATENCY          8'h00
`define AMC_LINE_SIZE        8'h00
`define AMC_SELF_TEST        8'h00
`define AMC_RANGE_RESET      32'h0000_0000

`endif

// ---- verilog/amc_pkg.sv ----
// types for the address-map configuration header block
// assumes the defs header is on the include path
`include "amc_defs.svh"

package amc_pkg;

   // ---------------------------------------------------------
   // configuration access request
   // ---------------------------------------------------------
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  offset;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } amc_req_t;

   // ---------------------------------------------------------
   // read answer
   // ---------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic [31:0] rdata;
   } amc_rsp_t;

   typedef enum logic [0:0] {
      AMC_IDLE = 1'b0,
      AMC_BUSY = 1'b1
   } amc_state_t;

endpackage : amc_pkg

// ---- verif/amc_monitor.sv ----
// assertions on the config header block ports
// assumes bind onto amc_config_header, one clock
`timescale 1ns/1ns
module amc_monitor (
   // clock, reset
   input wire logic              clock_in,
   input wire logic              reset_in,
   // config port
   input wire amc_pkg::amc_req_t req_in,
   input wire amc_pkg::amc_rsp_t rsp_out,
   input wire logic              wr_done_out
);
   import amc_pkg::*;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);
   // a write wins over a read in the same cycle
   wire logic       rd = req_in.rd & ~req_in.wr;
   wire logic [5:0] w  = req_in.offset[7:2];
   sequence s_rd(int a); rd && w == a; endsequence
   sequence s_wr_rd;
      req_in.wr && req_in.byte_en == 4'hf && w >= 6'h18 && w <= 6'h3c
      ##1 rd && w == $past(w);
   endsequence
   read_answer_a: assert property (rd |=> rsp_out.valid)
      else $error("read not answered");
   no_answer_a: assert property (!rd |=> !rsp_out.valid)
      else $error("answer without read");
   write_done_a: assert property (req_in.wr |=> wr_done_out)
      else $error("write not done");
   class_word_a: assert property (s_rd(2) |=>
      rsp_out.rdata[31:8] == 24'h060000) else $error("class word wrong");
   header_word_a: assert property (s_rd(3) |=>
      rsp_out.rdata == 32'h0080_0000) else $error("header word wrong");
   std_zero_a: assert property (
      rd && w < 6'h10 && w != 6'h00 && w != 6'h02 && w != 6'h03
      |=> rsp_out.rdata == 32'h0) else $error("unused word not zero");
   data_hold_a: assert property (!rsp_out.valid && !$past(reset_in)
      |-> $stable(rsp_out.rdata)) else $error("read data moved");
   range_back_a: assert property (s_wr_rd |=>
      rsp_out.rdata == $past(req_in.wdata, 2)) else $error("range word lost");
endmodule : amc_monitor

bind amc_config_header amc_monitor mon (.clock_in(clock_in),
   .reset_in(reset_in), .req_in(req_in), .rsp_out(rsp_out),
   .wr_done_out(wr_done_out));

// ---- verif/amc_config_header_tb_top.sv ----
// bench for the config header block
// assumes design, package and monitor compiled first
`timescale 1ns/1ns
module amc_config_header_tb_top;
   import amc_pkg::*;
   // arbitrary identity values
   localparam logic [15:0] MK = 16'h3c3c;
   localparam logic [15:0] FN = 16'h0002;
   localparam logic [7:0]  RV = 8'h07;
   logic        clock_in = 0;
   logic        reset_in = 1;
   amc_req_t    req = '0;
   amc_rsp_t    rsp;
   logic        wd;
   logic [31:0] rv;
   int          n_fail = 0;
   int          cmp_count = 0;
   amc_config_header #(.MAKER_IDENT(MK), .FUNCTION_IDENT(FN), .REVISION(RV))
      dut (.clock_in(clock_in), .reset_in(reset_in), .req_in(req),
           .rsp_out(rsp), .wr_done_out(wd));
   always #10 clock_in = ~clock_in;
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // one request; answer looked at one cycle later
   task acc(input logic w, input logic [7:0] o, input logic [31:0] d,
            input logic [3:0] be = 4'hf);
      @(posedge clock_in);
      #1 req = '{rd: !w, wr: w, offset: o, byte_en: be, wdata: d};
      @(posedge clock_in);
      #1 req = '0;
      chk(32'(w ? wd : rsp.valid), 32'h1);
      rv = rsp.rdata;
   endtask : acc
   function automatic logic [31:0] hdr(input logic [7:0] o);
      case (o)
         8'h00: hdr = {FN, MK};
         8'h08: hdr = {24'h060000, RV};
         8'h0c: hdr = 32'h0080_0000;
         default: hdr = 32'h0;
      endcase
   endfunction : hdr
   // writes of all ones must not stick in the header
   task t_header;
      for (int o = 0; o < 'h40; o += 4) begin
         acc(1, o[7:0], '1);
         acc(0, o[7:0], '0);
         chk(rv, hdr(o[7:0]));
      end
   endtask : t_header
   // stays on implemented extended words 0x60..0xf0 only
   task t_ranges;
      acc(0, 8'hf0, '0);
      chk(rv, 32'h0);
      for (int o = 'h60; o <= 'hf0; o += 4)
         acc(1, o[7:0], {4{o[7:0]}});
      for (int o = 'h60; o <= 'hf0; o += 4) begin
         acc(0, o[7:0], '0);
         chk(rv, {4{o[7:0]}});
      end
      acc(1, 8'h84, 32'h1122_3344, 4'h5);
      acc(0, 8'h84, '0);
      chk(rv, 32'h8422_8444);
      // write then read back to back
      @(posedge clock_in);
      #1 req = '{rd: 0, wr: 1, offset: 8'he4, byte_en: 4'hf,
                 wdata: 32'hcafe_0e40};
      @(posedge clock_in);
      #1 req = '{rd: 1, wr: 0, offset: 8'he4, byte_en: 4'h0, wdata: 32'h0};
      @(posedge clock_in);
      #1 req = '0;
      chk(32'(rsp.valid), 32'h1);
      chk(rsp.rdata, 32'hcafe_0e40);
   endtask : t_ranges
   // read and write together, then a mid-run reset
   task t_reset;
      @(posedge clock_in);
      #1 req = '{rd: 1, wr: 1, offset: 8'h88, byte_en: 4'hf,
                 wdata: 32'h0bad_f00d};
      @(posedge clock_in);
      #1 req = '0;
      chk(32'({rsp.valid, wd}), 32'h1);
      acc(0, 8'h88, '0);
      chk(rv, 32'h0bad_f00d);
      @(posedge clock_in);
      #1 reset_in = 1;
      repeat (2) @(posedge clock_in);
      #1 reset_in = 0;
      chk(32'({rsp.valid, wd}), 32'h0);
      acc(0, 8'h88, '0);
      chk(rv, 32'h0);
   endtask : t_reset
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   initial begin
      repeat (8) @(posedge clock_in);
      #1 reset_in = 0;
      t_header;
      t_ranges;
      t_reset;
      test_done;
   end
endmodule : amc_config_header_tb_top
